/* File: hfc_host.v */
// What this block does
// - Byte-width select rises only after write margin
// - Write and erase use two-cycle sequences
// - No new write sequence while device is busy, unless it is marked as suspend
// - Modify refused until protect confirm after reset, except erase-all
// - Wait 480 ns recovery after reset release
// - Reset pin held low until software releases
`timescale 1ns/1ps
`include "hfc_regs.vh"

module hfc_host #(
    parameter AW = 18
) (
    input  wire          clk,
    input  wire          rst_n,
    input  wire [3:0]    reg_addr,
    input  wire [31:0]   reg_wdata,
    input  wire          reg_wr,
    input  wire          reg_rd,
    output reg  [31:0]   reg_rdata,
    output wire [AW-1:0] fl_addr,
    output wire          fl_ce_n,
    output wire          fl_oe_n,
    output wire          fl_we_n,
    output wire [15:0]   fl_dq_o,
    output wire [15:0]   fl_dq_oe,
    input  wire [15:0]   fl_dq_i,
    output wire          byte_width_select_n,
    output wire          reset_powerdown_n,
    input  wire          ready_busy_od
);

    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_CYCLE = 2'h1;
    localparam [1:0] ST_CLOSE = 2'h2;

    localparam integer MARGIN_C  = `HFC_BWS_MARGIN_CYC;
    localparam integer RECOVER_C = `HFC_RECOVERY_CYC;
    localparam integer PD_LOW_C  = `HFC_PD_LOW_CYC;

    reg  [1:0]    state_r;
    reg  [1:0]    idx_r;
    reg  [1:0]    last_r;
    reg           wr_seq_r;
    reg  [7:0]    ctrl_r;
    reg  [AW-1:0] addr_r;
    reg  [16:0]   data0_r;
    reg  [16:0]   data1_r;
    reg  [16:0]   data2_r;
    reg           hold_pd_r;
    reg           x8_cfg_r;
    reg           bws_n_r;
    reg           rpn_r;
    reg           protect_r;
    reg           refused_r;
    reg           done_st_r;
    reg  [15:0]   rdbuf_r;
    reg  [16:0]   cyc_data;
    reg           go_ok;

    wire          go;
    wire [1:0]    go_kind;
    wire          go_modify;
    wire          eng_start;
    wire          eng_busy;
    wire          eng_done;
    wire [15:0]   eng_rdata;
    wire          margin_run;
    wire          recover_run;
    wire          pd_run;
    wire          rp_rise;
    wire          rp_fall;
    wire          seq_busy;

    // Software requests a sequence by writing the control word with go set.
    assign go        = reg_wr && (reg_addr == `HFC_OFS_CTRL) && reg_wdata[`HFC_CTRL_GO];
    assign go_kind   = reg_wdata[`HFC_CTRL_KIND_HI:`HFC_CTRL_KIND_LO];
    assign go_modify = reg_wdata[`HFC_CTRL_MODIFY];
    assign seq_busy  = (state_r != ST_IDLE);

    // Admission check for a new sequence. The pin reads high when every wired device is ready.
    // A refused request leaves the pins untouched and only sets the refused flag.
    always @*
    begin
        go_ok = 1'b1;
        if (seq_busy || !rpn_r || recover_run)
            go_ok = 1'b0;
        if (x8_cfg_r != ~bws_n_r)
            go_ok = 1'b0;
        if (!ready_busy_od && (go_kind != `HFC_KIND_READ) && !reg_wdata[`HFC_CTRL_SUSPEND])
            go_ok = 1'b0;
        if ((go_kind == `HFC_KIND_WR3) && bws_n_r)
            go_ok = 1'b0;
        if (go_modify && !protect_r && !reg_wdata[`HFC_CTRL_ERASE_ALL])
            go_ok = 1'b0;
    end

    // Data and byte-select of the cycle about to start; a chained start looks one index ahead.
    always @*
    begin
        case (eng_done ? idx_r + 2'h1 : idx_r)
            2'h0:    cyc_data = data0_r;
            2'h1:    cyc_data = data1_r;
            default: cyc_data = data2_r;
        endcase
    end

    // The first cycle starts on admission, later cycles as soon as the previous one ends.
    assign eng_start = (state_r == ST_CYCLE) && !eng_busy && !eng_done ||
                       (state_r == ST_CYCLE) && eng_done && (idx_r != last_r);

    // Sequencer: walks the one to three bus cycles of a command sequence.
    always @(posedge clk)
    begin
        if (!rst_n || !rpn_r)
        begin
            state_r  <= ST_IDLE;
            idx_r    <= 2'h0;
            last_r   <= 2'h0;
            wr_seq_r <= 1'b0;
            ctrl_r   <= 8'h00;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    if (go && go_ok)
                    begin
                        state_r  <= ST_CYCLE;
                        idx_r    <= 2'h0;
                        ctrl_r   <= reg_wdata[7:0];
                        wr_seq_r <= (go_kind != `HFC_KIND_READ);
                        last_r   <= (go_kind == `HFC_KIND_READ) ? 2'h0 : go_kind - 2'h1;
                    end
                end
                ST_CYCLE:
                begin
                    if (eng_done)
                    begin
                        if (idx_r == last_r)
                            state_r <= ST_CLOSE;
                        else
                            idx_r <= idx_r + 2'h1;
                    end
                end
                ST_CLOSE:
                    state_r <= ST_IDLE;
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // Protect flag: cleared by power-down, set by a completed protect confirm or erase-all.
    // The device's own lock bits still decide per block; this only tracks whether they apply.
    always @(posedge clk)
    begin
        if (!rst_n || !rpn_r)
            protect_r <= 1'b0;
        else if ((state_r == ST_CLOSE) && (ctrl_r[`HFC_CTRL_PROTECT] || ctrl_r[`HFC_CTRL_ERASE_ALL]))
            protect_r <= 1'b1;
    end

    // Sticky status flags: a new event in the clearing cycle wins over the clear.
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            refused_r <= 1'b0;
            done_st_r <= 1'b0;
            rdbuf_r   <= 16'h0000;
        end
        else
        begin
            if (go && !go_ok)
                refused_r <= 1'b1;
            else if (reg_wr && (reg_addr == `HFC_OFS_STATUS) && reg_wdata[`HFC_ST_REFUSED])
                refused_r <= 1'b0;
            if (state_r == ST_CLOSE)
                done_st_r <= 1'b1;
            else if (reg_wr && (reg_addr == `HFC_OFS_STATUS) && reg_wdata[`HFC_ST_DONE])
                done_st_r <= 1'b0;
            if (eng_done && !wr_seq_r)
                rdbuf_r <= eng_rdata;
        end
    end

    // Software registers. Address and data may not change while a sequence runs.
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            addr_r    <= {AW{1'b0}};
            data0_r   <= 17'h00000;
            data1_r   <= 17'h00000;
            data2_r   <= 17'h00000;
            {x8_cfg_r, hold_pd_r} <= `HFC_CFG_RESET;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `HFC_OFS_ADDR:  if (!seq_busy) addr_r  <= reg_wdata[AW-1:0];
                `HFC_OFS_DATA0: if (!seq_busy) data0_r <= reg_wdata[16:0];
                `HFC_OFS_DATA1: if (!seq_busy) data1_r <= reg_wdata[16:0];
                `HFC_OFS_DATA2: if (!seq_busy) data2_r <= reg_wdata[16:0];
                `HFC_OFS_CFG:
                begin
                    hold_pd_r <= reg_wdata[`HFC_CFG_HOLD_PD];
                    x8_cfg_r  <= reg_wdata[`HFC_CFG_X8];
                end
                default:
                    hold_pd_r <= hold_pd_r;
            endcase
        end
    end

    // Byte width follows the setting only when idle and after the write margin has run out.
    // Rising together with the write strobe would lose the byte-select bit in the device.
    always @(posedge clk)
    begin
        if (!rst_n)
            bws_n_r <= 1'b1;
        else if (!seq_busy && !eng_busy && !eng_done && !margin_run)
            bws_n_r <= ~x8_cfg_r;
    end

    // Reset pin: low through reset and while held, with a least low time before release.
    always @(posedge clk)
    begin
        if (!rst_n)
            rpn_r <= 1'b0;
        else if (hold_pd_r)
            rpn_r <= 1'b0;
        else if (!pd_run)
            rpn_r <= 1'b1;
    end

    assign rp_rise = !rpn_r && !hold_pd_r && !pd_run && rst_n;
    assign rp_fall = rpn_r && hold_pd_r;

    // Register read port: data stands in the cycle after the read strobe.
    always @(posedge clk)
    begin
        if (!rst_n)
            reg_rdata <= 32'h00000000;
        else if (reg_rd)
        begin
            case (reg_addr)
                `HFC_OFS_CTRL:   reg_rdata <= {24'h000000, ctrl_r};
                `HFC_OFS_ADDR:   reg_rdata <= {{(32-AW){1'b0}}, addr_r};
                `HFC_OFS_DATA0:  reg_rdata <= {15'h0000, data0_r};
                `HFC_OFS_DATA1:  reg_rdata <= {15'h0000, data1_r};
                `HFC_OFS_DATA2:  reg_rdata <= {15'h0000, data2_r};
                `HFC_OFS_CFG:    reg_rdata <= {30'h00000000, x8_cfg_r, hold_pd_r};
                `HFC_OFS_STATUS: reg_rdata <= {24'h000000, done_st_r, ~bws_n_r, rpn_r, recover_run,
                                               protect_r, refused_r, ready_busy_od, seq_busy};
                `HFC_OFS_RDATA:  reg_rdata <= {16'h0000, rdbuf_r};
                default:         reg_rdata <= 32'h00000000;
            endcase
        end
    end

    // Bus cycle engine; power-down aborts a cycle in flight.
    hfc_buscycle #(
        .AW      (AW)
    ) u_cycle (
        .clk     (clk),
        .rst_n   (rst_n),
        .start   (eng_start),
        .abort   (!rpn_r),
        .write   (wr_seq_r),
        .x8      (~bws_n_r),
        .addr    (addr_r),
        .bsel    (cyc_data[`HFC_DATA_BSEL]),
        .wdata   (cyc_data[15:0]),
        .dq_i    (fl_dq_i),
        .busy    (eng_busy),
        .done    (eng_done),
        .rdata   (eng_rdata),
        .fl_addr (fl_addr),
        .ce_n    (fl_ce_n),
        .oe_n    (fl_oe_n),
        .we_n    (fl_we_n),
        .dq_o    (fl_dq_o),
        .dq_oe   (fl_dq_oe)
    );

    // Margin after each write cycle before the byte width may change.
    hfc_countdown #(
        .W       (4)
    ) u_margin (
        .clk     (clk),
        .rst_n   (rst_n),
        .load    (eng_done && wr_seq_r),
        .value   (MARGIN_C[3:0]),
        .running (margin_run),
        .done    ()
    );

    // Least low time of the reset pin before release.
    hfc_countdown #(
        .W       (4)
    ) u_pdlow (
        .clk     (clk),
        .rst_n   (rst_n),
        .load    (rp_fall || !rst_n),
        .value   (PD_LOW_C[3:0]),
        .running (pd_run),
        .done    ()
    );

    // Recovery after the reset pin rises; no sequence is admitted meanwhile.
    hfc_countdown #(
        .W       (4)
    ) u_recover (
        .clk     (clk),
        .rst_n   (rst_n),
        .load    (rp_rise),
        .value   (RECOVER_C[3:0]),
        .running (recover_run),
        .done    ()
    );

    assign byte_width_select_n = bws_n_r;
    assign reset_powerdown_n   = rpn_r;

endmodule // hfc_host

/* File: hfc_regs.vh */
`ifndef HFC_REGS_VH
`define HFC_REGS_VH

// Register offsets of the controller's own register port.
`define HFC_OFS_CTRL        4'h0
`define HFC_OFS_ADDR        4'h1
`define HFC_OFS_DATA0       4'h2
`define HFC_OFS_DATA1       4'h3
`define HFC_OFS_DATA2       4'h4
`define HFC_OFS_CFG         4'h5
`define HFC_OFS_STATUS      4'h6
`define HFC_OFS_RDATA       4'h7

// Control register fields; a write with the go bit set launches a sequence.
`define HFC_CTRL_GO         0
`define HFC_CTRL_KIND_LO    1
`define HFC_CTRL_KIND_HI    2
`define HFC_CTRL_SUSPEND    4
`define HFC_CTRL_MODIFY     5
`define HFC_CTRL_PROTECT    6
`define HFC_CTRL_ERASE_ALL  7

// Sequence kinds: one read, or one to three write cycles.
`define HFC_KIND_READ       2'h0
`define HFC_KIND_WR1        2'h1
`define HFC_KIND_WR2        2'h2
`define HFC_KIND_WR3        2'h3

// Data register fields: data word and the byte-select bit of that cycle.
`define HFC_DATA_BSEL       16

// Configuration register fields and reset value (device held in power-down).
`define HFC_CFG_HOLD_PD     0
`define HFC_CFG_X8          1
`define HFC_CFG_RESET       2'h1

// Status register fields.
`define HFC_ST_BUSY         0
`define HFC_ST_READY_PIN    1
`define HFC_ST_REFUSED      2
`define HFC_ST_PROTECT      3
`define HFC_ST_RECOVER      4
`define HFC_ST_RP_LEVEL     5
`define HFC_ST_X8           6
`define HFC_ST_DONE         7

// Default command codes of the device.
`define HFC_CMD_READ_ARRAY  8'hff
`define HFC_CMD_READ_STATUS 8'h70
`define HFC_CMD_CLR_STATUS  8'h50
`define HFC_CMD_WORD_WRITE  8'h40
`define HFC_CMD_ERASE       8'h20
`define HFC_CMD_CONFIRM     8'hd0
`define HFC_CMD_SUSPEND     8'hb0

// Timing: figures in ns and derived cycle counts at the 50 ns clock.
`define HFC_CLK_NS          50
`define HFC_BWS_MARGIN_NS   10
`define HFC_RECOVERY_NS     480
`define HFC_ACCESS_NS       80
`define HFC_WE_PULSE_NS     100
`define HFC_PD_LOW_NS       100
`define HFC_BWS_MARGIN_CYC  ((`HFC_BWS_MARGIN_NS + `HFC_CLK_NS) / `HFC_CLK_NS)
`define HFC_RECOVERY_CYC    ((`HFC_RECOVERY_NS + `HFC_CLK_NS - 1) / `HFC_CLK_NS)
`define HFC_ACCESS_CYC      ((`HFC_ACCESS_NS + `HFC_CLK_NS - 1) / `HFC_CLK_NS)
`define HFC_WE_PULSE_CYC    ((`HFC_WE_PULSE_NS + `HFC_CLK_NS - 1) / `HFC_CLK_NS)
`define HFC_PD_LOW_CYC      ((`HFC_PD_LOW_NS + `HFC_CLK_NS - 1) / `HFC_CLK_NS)
`define HFC_SETUP_CYC       1
`define HFC_HOLD_CYC        1

`endif

/* File: hfc_countdown.v */
`timescale 1ns/1ps

module hfc_countdown #(
    parameter W = 8
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire         load,
    input  wire [W-1:0] value,
    output wire         running,
    output reg          done
);

    reg [W-1:0] cnt_r;

    // Counts a loaded value down to zero; done pulses for one cycle at expiry.
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt_r <= {W{1'b0}};
            done  <= 1'b0;
        end
        else if (load)
        begin
            cnt_r <= value;
            done  <= 1'b0;
        end
        else
        begin
            done <= (cnt_r == {{(W-1){1'b0}}, 1'b1});
            if (cnt_r != {W{1'b0}})
                cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
        end
    end

    // A load also counts as running so that no gap appears on reload.
    assign running = load | (cnt_r != {W{1'b0}});

endmodule // hfc_countdown

/* File: hfc_buscycle.v */
`timescale 1ns/1ps
`include "hfc_regs.vh"

module hfc_buscycle #(
    parameter AW = 18
) (
    input  wire          clk,
    input  wire          rst_n,
    input  wire          start,
    input  wire          abort,
    input  wire          write,
    input  wire          x8,
    input  wire [AW-1:0] addr,
    input  wire          bsel,
    input  wire [15:0]   wdata,
    input  wire [15:0]   dq_i,
    output wire          busy,
    output reg           done,
    output reg  [15:0]   rdata,
    output reg  [AW-1:0] fl_addr,
    output reg           ce_n,
    output reg           oe_n,
    output reg           we_n,
    output reg  [15:0]   dq_o,
    output reg  [15:0]   dq_oe
);

    localparam [1:0] S_IDLE   = 2'h0;
    localparam [1:0] S_SETUP  = 2'h1;
    localparam [1:0] S_STROBE = 2'h2;
    localparam [1:0] S_HOLD   = 2'h3;

    localparam integer SETUP_C = `HFC_SETUP_CYC;
    localparam integer WE_C    = `HFC_WE_PULSE_CYC;
    localparam integer RD_C    = `HFC_ACCESS_CYC;
    localparam integer HOLD_C  = `HFC_HOLD_CYC;

    reg [1:0] state_r;
    reg [3:0] cnt_r;
    reg       wr_r;

    assign busy = (state_r != S_IDLE);

    // One bus cycle: address and data settle, strobe low, strobe high with data still driven.
    // Address and data are held past the rising write strobe because the device latches there.
    always @(posedge clk)
    begin
        if (!rst_n || abort)
        begin
            state_r <= S_IDLE;
            cnt_r   <= 4'h0;
            wr_r    <= 1'b0;
            done    <= 1'b0;
            rdata   <= 16'h0000;
            fl_addr <= {AW{1'b0}};
            ce_n    <= 1'b1;
            oe_n    <= 1'b1;
            we_n    <= 1'b1;
            dq_o    <= 16'h0000;
            dq_oe   <= 16'h0000;
        end
        else
        begin
            done <= 1'b0;
            case (state_r)
                S_IDLE:
                begin
                    if (start)
                    begin
                        state_r <= S_SETUP;
                        cnt_r   <= SETUP_C[3:0];
                        wr_r    <= write;
                        fl_addr <= addr;
                        ce_n    <= 1'b0;
                        // In byte mode the top data line carries the byte-select bit.
                        if (x8)
                        begin
                            dq_o  <= {bsel, 7'h00, wdata[7:0]};
                            dq_oe <= write ? 16'h80ff : 16'h8000;
                        end
                        else
                        begin
                            dq_o  <= wdata;
                            dq_oe <= write ? 16'hffff : 16'h0000;
                        end
                    end
                end
                S_SETUP:
                begin
                    if (cnt_r <= 4'h1)
                    begin
                        state_r <= S_STROBE;
                        cnt_r   <= wr_r ? WE_C[3:0] : RD_C[3:0];
                        we_n    <= ~wr_r;
                        oe_n    <= wr_r;
                    end
                    else
                        cnt_r <= cnt_r - 4'h1;
                end
                S_STROBE:
                begin
                    if (cnt_r <= 4'h1)
                    begin
                        state_r <= S_HOLD;
                        cnt_r   <= HOLD_C[3:0];
                        we_n    <= 1'b1;
                        oe_n    <= 1'b1;
                        if (!wr_r)
                            rdata <= x8 ? {8'h00, dq_i[7:0]} : dq_i;
                    end
                    else
                        cnt_r <= cnt_r - 4'h1;
                end
                S_HOLD:
                begin
                    if (cnt_r <= 4'h1)
                    begin
                        state_r <= S_IDLE;
                        done    <= 1'b1;
                        ce_n    <= 1'b1;
                        dq_oe   <= 16'h0000;
                    end
                    else
                        cnt_r <= cnt_r - 4'h1;
                end
                default:
                    state_r <= S_IDLE;
            endcase
        end
    end

endmodule // hfc_buscycle

/* File: hfc_checker.sv */
`timescale 1ns/1ps
// Watches the flash pins of the host controller.
module hfc_checker #(
    parameter AW = 18
) (
    input wire          clk,
    input wire          rst_n,
    input wire [AW-1:0] fl_addr,
    input wire          fl_ce_n,
    input wire          fl_oe_n,
    input wire          fl_we_n,
    input wire [15:0]   fl_dq_o,
    input wire [15:0]   fl_dq_oe,
    input wire          byte_width_select_n,
    input wire          reset_powerdown_n
);
    // All checks share one clock and the controller reset.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Width select moves only while the write strobe is already high and idle.
    bws_margin_a: assert property ($changed(byte_width_select_n) |-> fl_we_n && fl_ce_n)
        else $error("byte width select moved during a write");
    we_frame_a: assert property (!fl_we_n |-> !fl_ce_n && fl_oe_n && reset_powerdown_n)
        else $error("write strobe outside a selected write cycle");
    wr_hold_a: assert property ($rose(fl_we_n) |-> $stable(fl_dq_o) && $stable(fl_addr) && !fl_ce_n)
        else $error("address or data moved at the rising write strobe");
    wr_lanes_a: assert property (!fl_we_n |-> fl_dq_oe == (byte_width_select_n ? 16'hffff : 16'h80ff))
        else $error("wrong driven data lanes on a write");
    rd_lanes_a: assert property (!fl_oe_n |-> fl_we_n && fl_dq_oe == (byte_width_select_n ? 16'h0 : 16'h8000))
        else $error("wrong driven data lanes on a read");
    // The reset pin stays low out of controller reset until software lets go.
    pd_release_a: assert property ($rose(rst_n) |-> !reset_powerdown_n)
        else $error("reset pin high right after controller reset");
    pd_quiet_a: assert property (!reset_powerdown_n && $past(!reset_powerdown_n)
        |-> fl_ce_n && fl_we_n && fl_oe_n && fl_dq_oe == 16'h0000)
        else $error("bus active while the device is held in reset");
    // Ten cycles of 50 ns cover the 480 ns recovery.
    recovery_a: assert property ($rose(reset_powerdown_n) |-> fl_ce_n [*8] ##1 fl_ce_n [*2])
        else $error("device selected during reset recovery");
endmodule // hfc_checker

bind hfc_host hfc_checker #(.AW(AW)) chk_u (
    .clk(clk), .rst_n(rst_n), .fl_addr(fl_addr), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe),
    .byte_width_select_n(byte_width_select_n), .reset_powerdown_n(reset_powerdown_n));

/* File: hfc_flash_model.sv */
`timescale 1ns/1ps
// Behavioural flash device: command interface, one busy timer, erase suspend.
module hfc_flash_model #(
    parameter BUSY_NS = 3000
) (
    input  wire [17:0] addr,
    input  wire        ce_n,
    input  wire        oe_n,
    input  wire        we_n,
    input  wire        byte_width_select_n,
    input  wire        reset_powerdown_n,
    input  wire [15:0] dq_in,
    output wire [15:0] dq_out,
    output wire        ry_low
);
    reg  [7:0]  cmd_r;
    reg  [15:0] mem_r [0:63];
    reg         busy_r;
    reg         susp_r;
    reg         rec_r;
    wire [15:0] word = mem_r[addr[5:0]];
    wire [15:0] val;

    // Commands are taken on the rising write strobe; a low reset pin aborts all.
    always @(posedge we_n or negedge reset_powerdown_n)
    begin
        if (!reset_powerdown_n)
        begin
            busy_r <= 1'b0;
            susp_r <= 1'b0;
            cmd_r  <= 8'hff;
        end
        else if (!ce_n)
        begin
            if (busy_r && !susp_r)
                susp_r <= (dq_in[7:0] == 8'hb0);
            else if (cmd_r == 8'h40)
            begin
                mem_r[addr[5:0]] <= byte_width_select_n ? dq_in : {8'h00, dq_in[7:0]};
                busy_r <= 1'b1;
                cmd_r  <= 8'h70;
            end
            else if (dq_in[7:0] == 8'hd0 && (cmd_r == 8'h20 || susp_r))
            begin
                busy_r <= 1'b1;
                susp_r <= 1'b0;
                cmd_r  <= 8'h70;
            end
            else
                cmd_r <= dq_in[7:0];
        end
    end

    // The internal algorithm cannot finish while suspended; its timer keeps running.
    always @(posedge busy_r)
    begin
        #(BUSY_NS);
        wait (!susp_r);
        busy_r <= 1'b0;
    end

    // Outputs are not valid until 480 ns after the reset pin rises.
    always @(reset_powerdown_n)
    begin
        rec_r = 1'b0;
        #480 rec_r = reset_powerdown_n;
    end

    // Undriven lines show the inverse, so a stale value never looks valid.
    assign val = (cmd_r == 8'h70) ? {8'h00, !busy_r || susp_r, susp_r, 6'h00}
               : byte_width_select_n ? word : {8'h00, dq_in[15] ? word[15:8] : word[7:0]};
    assign dq_out = (!ce_n && !oe_n && rec_r === 1'b1) ? val : ~val;
    assign ry_low = reset_powerdown_n && busy_r && !susp_r;
endmodule // hfc_flash_model

/* File: testbench.sv */
`timescale 1ns/1ps
`include "hfc_regs.vh"
module testbench;
    reg         clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    reg  [3:0]  reg_addr = 4'h0;
    reg  [31:0] reg_wdata = 32'h0, v;
    wire [31:0] reg_rdata;
    wire [17:0] fl_addr;
    wire        fl_ce_n, fl_oe_n, fl_we_n, byte_width_select_n, reset_powerdown_n, ry_low;
    wire [15:0] fl_dq_o, fl_dq_oe, mdl_dq;
    wire [15:0] dq_pin = (fl_dq_oe & fl_dq_o) | (~fl_dq_oe & mdl_dq);
    integer     failures = 0, n_tests = 0, cycles = 0;

    always #25 clk = ~clk;

    hfc_host #(.AW(18)) dut_u (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fl_addr(fl_addr), .fl_ce_n(fl_ce_n),
        .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe),
        .fl_dq_i(dq_pin), .byte_width_select_n(byte_width_select_n),
        .reset_powerdown_n(reset_powerdown_n), .ready_busy_od(!ry_low));
    hfc_flash_model mdl_u (
        .addr(fl_addr), .ce_n(fl_ce_n), .oe_n(fl_oe_n), .we_n(fl_we_n),
        .byte_width_select_n(byte_width_select_n), .reset_powerdown_n(reset_powerdown_n),
        .dq_in(dq_pin), .dq_out(mdl_dq), .ry_low(ry_low));

    task tally_and_finish;
    begin
        $display("comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask

    // A hung handshake ends the run as a mismatch.
    always @(posedge clk)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            failures = failures + 1;
            tally_and_finish;
        end
    end

    task chk(input [31:0] got, input [31:0] exp);
    begin
        n_tests = n_tests + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask

    task wr(input [3:0] a, input [31:0] d);
    begin
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    end
    endtask

    // Read data stand from the cycle after the strobe until the next read.
    task rd(input [3:0] a);
    begin
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        @(negedge clk);
        v = reg_rdata;
    end
    endtask

    // Compares masked status bits, then clears the sticky done and refused flags.
    task st(input [7:0] m, input [7:0] e);
    begin
        rd(`HFC_OFS_STATUS);
        chk(v & m, e);
        wr(`HFC_OFS_STATUS, 32'h84);
    end
    endtask

    // Loads the data words, launches a sequence and polls until done or refused.
    task go(input [7:0] c, input [15:0] d0, input [15:0] d1);
        integer i;
    begin
        wr(`HFC_OFS_STATUS, 32'h84);
        wr(`HFC_OFS_DATA0, {16'h0, d0});
        wr(`HFC_OFS_DATA1, {16'h0, d1});
        wr(`HFC_OFS_DATA2, 32'h0000_00d0);
        wr(`HFC_OFS_CTRL, {24'h0, c});
        v = 32'h0;
        for (i = 0; i < 60 && v[7] === 1'b0 && v[2] === 1'b0; i = i + 1)
            rd(`HFC_OFS_STATUS);
    end
    endtask

    task wait_ready;
        integer i;
    begin
        v = 32'h0;
        for (i = 0; i < 100 && v[1] !== 1'b1; i = i + 1)
            rd(`HFC_OFS_STATUS);
    end
    endtask

    task t_power_up;
    begin
        rd(`HFC_OFS_CFG);
        chk(v, 32'h1);
        rd(4'h9);
        chk(v, 32'h0);
        wr(`HFC_OFS_ADDR, 32'h3c005);
        go(8'h03, 16'hff, 16'h0);
        st(8'h24, 8'h04);
        wr(`HFC_OFS_CFG, 32'h0);
        go(8'h03, 16'hff, 16'h0);
        st(8'h04, 8'h04);
        repeat (12) @(posedge clk);
        st(8'h34, 8'h20);
    end
    endtask

    task t_lock_and_write;
    begin
        go(8'h25, 16'h40, 16'h1234);
        st(8'h8c, 8'h04);
        go(8'h43, 16'h57, 16'h0);
        st(8'h8c, 8'h88);
        go(8'h25, 16'h40, 16'h1234);
        chk(mdl_u.mem_r[5], 32'h1234);
        chk(fl_addr, 32'h3c005);
        st(8'h86, 8'h80);
        go(8'h23, 16'h70, 16'h0);
        st(8'h84, 8'h04);
        wait_ready;
        go(8'h03, 16'hff, 16'h0);
        go(8'h01, 16'h0, 16'h0);
        rd(`HFC_OFS_RDATA);
        chk(v, 32'h1234);
    end
    endtask

    task t_suspend_and_x8;
    begin
        go(8'h05, 16'h20, 16'hd0);
        st(8'h86, 8'h80);
        go(8'h13, 16'hb0, 16'h0);
        st(8'h86, 8'h82);
        go(8'h27, 16'h40, 16'h0);
        st(8'h84, 8'h04);
        wr(`HFC_OFS_CFG, 32'h2);
        repeat (4) @(posedge clk);
        chk(byte_width_select_n, 32'h0);
        go(8'h27, 16'h40, 16'h8011);
        st(8'hc4, 8'hc0);
        wr(`HFC_OFS_CFG, 32'h0);
        repeat (4) @(posedge clk);
        chk(byte_width_select_n, 32'h1);
    end
    endtask

    task t_abort_and_erase_all;
    begin
        wr(`HFC_OFS_CTRL, 32'h25);
        repeat (3) @(posedge clk);
        wr(`HFC_OFS_CFG, 32'h1);
        repeat (2) @(posedge clk);
        chk(reset_powerdown_n, 32'h0);
        st(8'h29, 8'h00);
        wr(`HFC_OFS_CFG, 32'h0);
        repeat (14) @(posedge clk);
        go(8'ha5, 16'ha7, 16'hd0);
        st(8'h8c, 8'h88);
    end
    endtask

    // Main sequence.
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_power_up;
        t_lock_and_write;
        t_suspend_and_x8;
        t_abort_and_erase_all;
        tally_and_finish;
    end
endmodule // testbench
